// ### design/buck_seq_pkg.sv
// Constants and carrier types for the buck startup and fault controller
// Functional notes
// (RL1) Capture current ceiling at address 21h once, when enable rises.
// (RL2) Ceiling code is one amp per bit; 2.5 V reads as 255.
// (RL3) Digitise output current monitor; 2.5 V equals full rated load.
// (RL4) Sample temperature input periodically, compare with fixed thermal thresholds.
// (RL5) Per-phase frequency 180 to 1170 kHz from fourth-pulse-pin resistor setting.
// (RL6) Phase ramps equally spaced; single rail halfway between phases one and two.
// (RL7) Ramp supply 4 V lockout honoured only while enabled.
// (RL8) Driver-on line low from driver holds off enable and startup.
// (RL9) After driver lockout releases, phase outputs go mid before soft start.
// (RL10) Soft start steps reference from zero to target at fixed rate.
// (RL11) Outputs float with test current first, to count phases and load settings.
// (RL12) After configuration and enable, drive mid level, then raise driver-on line.
// (RL13) Each phase leaves mid state at its own first switching pulse.
// (RL14) On disable every phase output returns to mid state.
// (RL15) Output 400 mV over reference drops ready flag, ramps target to zero.
// (RL16) Overvoltage commands all high sides off, low sides on.
// (RL17) Overvoltage shutdown latched until enable toggles or supply cycles.
// (RL18) Overcurrent 50 us latch-off timer; above 150 percent shut down at once.
// (RL19) Asynchronous comparator inputs synchronised before use.
// (RL20) Ready flag only after soft start completes with no fault.
package buck_seq_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned OC_DELAY_NS = 50_000;
  localparam int unsigned OC_DELAY_CYC = OC_DELAY_NS / (1_000_000_000 / CLK_HZ);
  localparam logic [7:0] CEILING_ADDR = 8'h21;
  localparam logic [7:0] ADC_FULL = 8'hFF;
  localparam logic [7:0] DAC_ZERO = 8'h00;
  localparam logic [7:0] TEMP_HOT = 8'hC0;
  localparam logic [7:0] TEMP_CRIT = 8'hE0;
  localparam logic [9:0] SS_STEP_CYC = 10'h3E8;
  localparam logic [9:0] ADC_PERIOD_CYC = 10'h3FF;
  localparam logic [4:0] CFG_CYC = 5'h1F;
  localparam logic [10:0] FREQ_MIN_KHZ = 11'h0B4;
  localparam logic [10:0] FREQ_MAX_KHZ = 11'h492;
  localparam int unsigned NPH = 4;
  // Four-level phase pulse drive
  typedef enum logic [1:0] {
    PH_LOW = 2'h0,
    PH_HIGH = 2'h1,
    PH_MID = 2'h2,
    PH_FLOAT = 2'h3
  } phase_lvl_type;
  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_CFG = 6'h02,
    ST_MID = 6'h04,
    ST_RAMP = 6'h08,
    ST_RUN = 6'h10,
    ST_FAULT = 6'h20
  } seq_state_type;
  // Asynchronous comparator bundle
  typedef struct packed {
    logic ovp;
    logic oc_limit;
    logic oc_severe;
    logic ramp_uvlo;
  } comp_type;
  // Analogue-to-digital results
  typedef struct packed {
    logic [7:0] ceiling;
    logic [7:0] output_current_monitor;
    logic [7:0] temp;
    logic [7:0] freq;
  } adc_type;
endpackage

// ### design/buck_seq_ctrl.sv
// Startup sequencing and protection controller for a multiphase buck
`timescale 1ns/10ps
module buck_seq_ctrl (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Enable and driver handshake
  input wire logic i_enable,
  input wire logic i_driver_on_line,
  // Comparators and converter results
  input wire buck_seq_pkg::comp_type i_comp,
  input wire buck_seq_pkg::adc_type i_adc,
  input wire logic [3:0] i_phase_present,
  input wire logic [3:0] i_pulse_req,
  input wire logic [7:0] i_target,
  // Register read port
  input wire logic [7:0] i_reg_addr,
  output logic [7:0] o_reg_data,
  // Outputs
  output buck_seq_pkg::phase_lvl_type o_phase [4],
  output logic o_driver_on_oe,
  output logic o_test_current,
  output logic [7:0] o_dac,
  output logic [7:0] o_output_current_monitor_reading,
  output logic [1:0] o_thermal,
  output logic [7:0] o_freq_setting,
  output logic [3:0] o_phase_offset,
  output logic o_regulator_ready_flag
);
  import buck_seq_pkg::*;

  seq_state_type state_reg;
  comp_type sync1_reg, sync2_reg;
  logic [1:0] drv_sync_reg;
  logic en_d_reg;
  logic [7:0] ceiling_reg;
  logic [3:0] populated_reg;
  logic [4:0] cfg_cnt_reg;
  logic [9:0] ss_cnt_reg;
  logic [9:0] adc_cnt_reg;
  logic [15:0] oc_cnt_reg;
  logic [3:0] fired_reg;
  logic mid_done_reg;
  logic [3:0] phase_offset_reg;
  logic fault_latch_reg;
  logic en_rise;
  logic drv_ok;
  logic uvlo_hit;
  logic oc_trip;

  // Comparator synchroniser, two stages
  // (RL19) sync async comparators
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= i_comp;
      sync2_reg <= sync1_reg;
    end
  end

  // Driver-on line synchroniser
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      drv_sync_reg <= 2'h0;
    end else begin
      drv_sync_reg <= {drv_sync_reg[0], i_driver_on_line};
    end
  end

  // Enable edge detector
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      en_d_reg <= 1'b0;
    end else begin
      en_d_reg <= i_enable;
    end
  end

  assign en_rise = i_enable && !en_d_reg;
  // (RL8) driver lockout holds off
  assign drv_ok = drv_sync_reg[1];
  // (RL7) lockout only while enabled
  assign uvlo_hit = i_enable && sync2_reg.ramp_uvlo;
  // (RL18) immediate on severe, else timer
  assign oc_trip = sync2_reg.oc_severe ||
                   (sync2_reg.oc_limit && oc_cnt_reg >= 16'(OC_DELAY_CYC - 1));

  // Current ceiling capture, linear one amp per code
  // (RL1) capture at enable
  // (RL2) code scale
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ceiling_reg <= 8'h00;
    end else if (en_rise) begin
      ceiling_reg <= i_adc.ceiling;
    end
  end

  // Register read: only the ceiling is mapped, others read zero
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_reg_data <= 8'h00;
    end else if (i_reg_addr == CEILING_ADDR) begin
      o_reg_data <= ceiling_reg;
    end else begin
      o_reg_data <= 8'h00;
    end
  end

  // Periodic monitor sampling; readings held between samples
  // (RL3) current monitor reading
  // (RL4) thermal compare
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      adc_cnt_reg <= 10'h000;
      o_output_current_monitor_reading <= 8'h00;
      o_thermal <= 2'h0;
    end else begin
      adc_cnt_reg <= (adc_cnt_reg == ADC_PERIOD_CYC) ? 10'h000 : adc_cnt_reg + 10'h001;
      if (adc_cnt_reg == ADC_PERIOD_CYC) begin
        o_output_current_monitor_reading <= i_adc.output_current_monitor;
        o_thermal <= {i_adc.temp >= TEMP_CRIT, i_adc.temp >= TEMP_HOT};
      end
    end
  end

  // Frequency setting and phase spacing, loaded during configuration
  // (RL5) frequency from pin resistor
  // (RL6) equal spacing, single rail at half step
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_freq_setting <= 8'h00;
      o_phase_offset <= 4'h0;
      populated_reg <= 4'h0;
    end else if (state_reg == ST_CFG && cfg_cnt_reg == CFG_CYC) begin
      // (RL11) phase count captured
      o_freq_setting <= i_adc.freq;
      populated_reg <= i_phase_present;
      case (i_phase_present)
        4'hF: o_phase_offset <= 4'h2;
        4'h7: o_phase_offset <= 4'h3;
        4'h5: o_phase_offset <= 4'h4;
        default: o_phase_offset <= 4'h8;
      endcase
    end
  end

  // Overcurrent latch-off timer
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      oc_cnt_reg <= 16'h0000;
    end else if (sync2_reg.oc_limit && (state_reg == ST_RAMP || state_reg == ST_RUN)) begin
      oc_cnt_reg <= oc_cnt_reg + 16'h0001;
    end else begin
      oc_cnt_reg <= 16'h0000;
    end
  end

  // Fault latch, released only by enable toggle or reset
  // (RL17) latched shutdown
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      fault_latch_reg <= 1'b0;
    end else if (!i_enable) begin
      fault_latch_reg <= 1'b0;
    end else if ((state_reg == ST_RAMP || state_reg == ST_RUN) &&
                 (sync2_reg.ovp || oc_trip)) begin
      fault_latch_reg <= 1'b1;
    end
  end

  // Sequencer state machine
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= ST_OFF;
      cfg_cnt_reg <= 5'h00;
      mid_done_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_OFF: begin
          cfg_cnt_reg <= 5'h00;
          mid_done_reg <= 1'b0;
          if (i_enable) begin
            state_reg <= ST_CFG;
          end
        end
        ST_CFG: begin
          cfg_cnt_reg <= cfg_cnt_reg + 5'h01;
          if (!i_enable) begin
            state_reg <= ST_OFF;
          end else if (cfg_cnt_reg == CFG_CYC) begin
            state_reg <= ST_MID;
          end
        end
        ST_MID: begin
          // (RL12) mid first, driver-on next
          mid_done_reg <= 1'b1;
          // (RL9) hold until driver ready
          if (!i_enable) begin
            state_reg <= ST_OFF;
          end else if (mid_done_reg && drv_ok && !uvlo_hit) begin
            state_reg <= ST_RAMP;
          end
        end
        ST_RAMP: begin
          if (!i_enable) begin
            state_reg <= ST_OFF;
          end else if (sync2_reg.ovp || oc_trip) begin
            state_reg <= ST_FAULT;
          end else if (!drv_ok || uvlo_hit) begin
            state_reg <= ST_MID;
          end else if (o_dac >= i_target) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!i_enable) begin
            state_reg <= ST_OFF;
          end else if (sync2_reg.ovp || oc_trip) begin
            state_reg <= ST_FAULT;
          end else if (!drv_ok || uvlo_hit) begin
            state_reg <= ST_MID;
          end
        end
        ST_FAULT: begin
          if (!i_enable) begin
            state_reg <= ST_OFF;
          end
        end
        default: state_reg <= ST_OFF;
      endcase
    end
  end

  // Soft-start counter; also ramps down on overvoltage
  // (RL10) fixed rate step
  // (RL15) target ramped to zero
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ss_cnt_reg <= 10'h000;
      o_dac <= DAC_ZERO;
    end else if (state_reg == ST_OFF || state_reg == ST_CFG || state_reg == ST_MID) begin
      ss_cnt_reg <= 10'h000;
      o_dac <= DAC_ZERO;
    end else if (ss_cnt_reg == SS_STEP_CYC - 10'h001) begin
      ss_cnt_reg <= 10'h000;
      if (state_reg == ST_FAULT && o_dac != DAC_ZERO) begin
        o_dac <= o_dac - 8'h01;
      end else if (state_reg != ST_FAULT && o_dac < i_target) begin
        o_dac <= o_dac + 8'h01;
      end
    end else begin
      ss_cnt_reg <= ss_cnt_reg + 10'h001;
    end
  end

  // First-pulse tracking per phase
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      fired_reg <= 4'h0;
    end else if (state_reg == ST_RAMP || state_reg == ST_RUN) begin
      fired_reg <= fired_reg | (i_pulse_req & populated_reg);
    end else begin
      fired_reg <= 4'h0;
    end
  end

  // Phase pulse output levels
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < NPH; k++) begin
        o_phase[k] <= PH_FLOAT;
      end
    end else begin
      for (int k = 0; k < NPH; k++) begin
        if (state_reg == ST_FAULT || fault_latch_reg) begin
          // (RL16) high off, low on
          o_phase[k] <= PH_LOW;
        end else if (state_reg == ST_CFG) begin
          // (RL11) float with test current
          o_phase[k] <= PH_FLOAT;
        end else if ((state_reg == ST_RAMP || state_reg == ST_RUN) &&
                     populated_reg[k] && (fired_reg[k] || i_pulse_req[k])) begin
          // (RL13) leave mid at first pulse
          o_phase[k] <= i_pulse_req[k] ? PH_HIGH : PH_LOW;
        end else begin
          // (RL14) mid when disabled or idle
          o_phase[k] <= PH_MID;
        end
      end
    end
  end

  // Driver-on, test current and ready flag
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_driver_on_oe <= 1'b1;
      o_test_current <= 1'b0;
      o_regulator_ready_flag <= 1'b0;
    end else begin
      // Open-drain: pulled low until mid level has been driven
      o_driver_on_oe <= !(state_reg == ST_RAMP || state_reg == ST_RUN ||
                          (state_reg == ST_MID && mid_done_reg));
      o_test_current <= (state_reg == ST_CFG);
      // (RL20) ready only after ramp, no fault
      o_regulator_ready_flag <= (state_reg == ST_RUN) && !sync2_reg.ovp && !fault_latch_reg;
    end
  end

  // Ready flag falls within four cycles of overvoltage
  a_ovp_ready_drop: assert property (@(posedge i_clk_sys) disable iff (i_reset) // (RL15)
    (i_comp.ovp && state_reg == ST_RUN && i_enable) |-> ##[1:4] !o_regulator_ready_flag)
    else $error("ready flag held during overvoltage");
  a_fault_low_side: assert property (@(posedge i_clk_sys) disable iff (i_reset) // (RL16)
    state_reg == ST_FAULT |=> o_phase[0] == PH_LOW && o_phase[3] == PH_LOW)
    else $error("fault not driving low sides");
  a_fault_latched: assert property (@(posedge i_clk_sys) disable iff (i_reset) // (RL17)
    (state_reg == ST_FAULT && i_enable) |=> state_reg == ST_FAULT)
    else $error("fault left without enable toggle");
  a_ready_after_ramp: assert property (@(posedge i_clk_sys) disable iff (i_reset) // (RL20)
    $rose(o_regulator_ready_flag) |-> $past(state_reg) == ST_RUN)
    else $error("ready without completed ramp");
  a_disable_mid: assert property (@(posedge i_clk_sys) disable iff (i_reset) // (RL14)
    (!i_enable ##1 !i_enable) |=> o_phase[1] == PH_MID)
    else $error("phase not mid when disabled");
  a_ceiling_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset) // (RL1)
    !en_rise |=> ceiling_reg == $past(ceiling_reg))
    else $error("ceiling changed without enable edge");
  a_cfg_float: assert property (@(posedge i_clk_sys) disable iff (i_reset) // (RL11)
    (state_reg == ST_CFG && !fault_latch_reg) |=> o_phase[2] == PH_FLOAT && o_test_current)
    else $error("configuration not floating");
  a_drv_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset) // (RL8)
    (state_reg == ST_MID && !drv_ok) |=> state_reg != ST_RAMP)
    else $error("startup despite driver lockout");
  a_dac_step: assert property (@(posedge i_clk_sys) disable iff (i_reset) // (RL10)
    (state_reg == ST_RAMP && $past(state_reg) == ST_RAMP) |-> o_dac - $past(o_dac) <= 8'h01)
    else $error("reference stepped too fast");
  c_reach_run: cover property (@(posedge i_clk_sys) state_reg == ST_RUN);
  c_ovp_fault: cover property (@(posedge i_clk_sys) state_reg == ST_FAULT && sync2_reg.ovp);
  c_oc_timer: cover property (@(posedge i_clk_sys) oc_trip && !sync2_reg.oc_severe);
endmodule // buck_seq_ctrl

// ### verif/gate_driver_model.sv
// Gate driver model that holds the driver-on line low on a weak supply
`timescale 1ns/10ps
module gate_driver_model #(
  parameter int HOLD_CYC = 16
) (
  // Clock
  input wire logic i_clk_sys,
  // Driver supply status
  input wire logic i_supply_ok,
  // Open-drain pull on driver-on line
  output logic o_pull_low
);
  int hold = 0;
  // minimum low hold
  // Hold outlasts short dips so the controller cannot start too early
  always_ff @(posedge i_clk_sys) begin
    if (!i_supply_ok) hold <= HOLD_CYC;
    else if (hold > 0) hold <= hold - 1;
  end
  assign o_pull_low = !i_supply_ok || (hold > 0);
endmodule // gate_driver_model

// ### verif/multiphase_buck_startup_fault_ctrl_bench.sv
// Self-checking bench for the buck startup and fault controller
`timescale 1ns/10ps
module multiphase_buck_startup_fault_ctrl_bench;
  import buck_seq_pkg::*;
  logic i_clk_sys, i_reset, i_enable, supply_ok, drv_pull, driver_on_line_wire;
  logic o_driver_on_oe, o_test_current, o_regulator_ready_flag;
  comp_type comp;
  adc_type adc;
  logic [3:0] i_phase_present, i_pulse_req, o_phase_offset;
  logic [7:0] i_target, i_reg_addr, o_reg_data, o_dac, o_output_current_monitor_reading, o_freq_setting;
  logic [1:0] o_thermal;
  phase_lvl_type ph [4];
  logic [31:0] seed = 32'h297F;
  int fails = 0;
  int n_tests = 0;
  int cyc;
  // Pulled-up open-drain wire: either party may pull it low
  assign driver_on_line_wire = !(o_driver_on_oe || drv_pull);
  buck_seq_ctrl dut_u (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_enable(i_enable),
    .i_driver_on_line(driver_on_line_wire), .i_comp(comp), .i_adc(adc),
    .i_phase_present(i_phase_present), .i_pulse_req(i_pulse_req), .i_target(i_target),
    .i_reg_addr(i_reg_addr), .o_reg_data(o_reg_data), .o_phase(ph),
    .o_driver_on_oe(o_driver_on_oe), .o_test_current(o_test_current), .o_dac(o_dac),
    .o_output_current_monitor_reading(o_output_current_monitor_reading), .o_thermal(o_thermal),
    .o_freq_setting(o_freq_setting), .o_phase_offset(o_phase_offset),
    .o_regulator_ready_flag(o_regulator_ready_flag));
  gate_driver_model drv_u (.i_clk_sys(i_clk_sys), .i_supply_ok(supply_ok), .o_pull_low(drv_pull));
  // Clock at 50 ns period
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic all_at(input phase_lvl_type l);
    return (ph[0] === l) && (ph[1] === l) && (ph[2] === l) && (ph[3] === l);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  // Bounded wait for every phase to reach one level
  task automatic wait_all(input phase_lvl_type l, input int lim);
    cyc = 0;
    while (!all_at(l) && cyc < lim) begin
      tick(1);
      cyc++;
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Enable, walk configuration and the soft-start ramp against an integer model
  task automatic start_up(input logic [7:0] tgt);
    int last, steps;
    logic [7:0] exp_dac, exp_ceil, exp_freq;
    seed = lfsr(seed);
    exp_ceil = seed[7:0];
    exp_freq = seed[15:8];
    adc.ceiling = exp_ceil;
    adc.freq = exp_freq;
    i_phase_present = 4'hF;
    i_target = tgt;
    i_enable = 1'b1;
    tick(3);
    adc.ceiling = ~exp_ceil;
    chk("test_current", o_test_current, 1'b1);
    chk("float", all_at(PH_FLOAT), 1'b1);
    wait_all(PH_MID, 40);
    chk("mid_first", o_driver_on_oe, 1'b1);
    tick(3);
    chk("driver_on_line_released", o_driver_on_oe, 1'b0);
    chk("freq", o_freq_setting, exp_freq);
    // Four populated phases, spacing counted in eighths of a period
    chk("phase_offset", o_phase_offset, 4'h2);
    exp_dac = 8'h00;
    last = 0;
    steps = 0;
    cyc = 0;
    while (o_regulator_ready_flag !== 1'b1 && cyc < 1000 * tgt + 2000) begin
      tick(1);
      cyc++;
      if (o_dac !== exp_dac) begin
        exp_dac++;
        chk("dac", o_dac, exp_dac);
        if (steps > 0) chk("step_gap", cyc - last, SS_STEP_CYC);
        last = cyc;
        steps++;
        if (steps == 1) begin
          i_pulse_req = 4'h1;
          tick(4);
          cyc += 4;
          chk("ph0_left", ph[0] !== PH_MID, 1'b1);
          chk("ph1_mid", ph[1], PH_MID);
        end
      end
    end
    chk("ready", o_regulator_ready_flag, 1'b1);
    chk("dac_final", o_dac, tgt);
    i_reg_addr = CEILING_ADDR;
    tick(2);
    chk("ceiling", o_reg_data, exp_ceil);
    i_reg_addr = 8'h22;
    tick(2);
    chk("unmapped", o_reg_data, 8'h00);
  endtask
  task automatic disable_all;
    i_enable = 1'b0;
    i_pulse_req = 4'h0;
    comp = '0;
    wait_all(PH_MID, 6);
    chk("disable_mid", cyc < 6, 1'b1);
    tick(4);
  endtask
  // Watchdog
  initial begin
    #(60000 * 50);
    fails++;
    conclude();
  end
  // Main sequence
  initial begin
    i_reset = 1'b1;
    i_enable = 1'b0;
    supply_ok = 1'b1;
    comp = '0;
    adc = '0;
    i_phase_present = 4'h0;
    i_pulse_req = 4'h0;
    i_target = 8'h00;
    i_reg_addr = 8'h00;
    tick(3);
    i_reset = 1'b0;
    chk("rst_ready", o_regulator_ready_flag, 1'b0);
    start_up(8'h03);
    supply_ok = 1'b0;
    wait_all(PH_MID, 8);
    chk("drv_mid", cyc < 8, 1'b1);
    chk("drv_ready", o_regulator_ready_flag, 1'b0);
    supply_ok = 1'b1;
    tick(8);
    chk("drv_hold_mid", all_at(PH_MID), 1'b1);
    disable_all();
    start_up(8'h02);
    comp.ramp_uvlo = 1'b1;
    wait_all(PH_MID, 8);
    chk("uvlo_mid", cyc < 8, 1'b1);
    disable_all();
    start_up(8'h02);
    seed = lfsr(seed);
    adc.output_current_monitor = seed[7:0];
    adc.temp = TEMP_CRIT;
    tick(1100);
    chk("output_current_monitor", o_output_current_monitor_reading, seed[7:0]);
    chk("thermal_crit", o_thermal, 2'b11);
    adc.temp = TEMP_HOT;
    tick(1100);
    chk("thermal_hot", o_thermal, 2'b01);
    comp.ovp = 1'b1;
    tick(1);
    chk("ovp_sync", all_at(PH_LOW), 1'b0);
    tick(4);
    chk("ovp_low", all_at(PH_LOW), 1'b1);
    chk("ovp_ready", o_regulator_ready_flag, 1'b0);
    tick(1005);
    chk("ovp_ramp_down", o_dac, 8'h01);
    comp.ovp = 1'b0;
    tick(20);
    chk("ovp_latched", all_at(PH_LOW), 1'b1);
    disable_all();
    start_up(8'h01);
    comp.oc_limit = 1'b1;
    tick(900);
    chk("oc_early", all_at(PH_LOW), 1'b0);
    tick(110);
    chk("oc_timed", all_at(PH_LOW), 1'b1);
    disable_all();
    start_up(8'h01);
    comp.oc_severe = 1'b1;
    tick(5);
    chk("oc_severe", all_at(PH_LOW), 1'b1);
    disable_all();
    conclude();
  end
endmodule // multiphase_buck_startup_fault_ctrl_bench
